// ==== lpc_params.svh ====
// How it works
// RL1 - clock monitor disabled: a crystal clock failure in wait is ignored
// RL2 - monitor on, self-clock off: failure in wait gives immediate clock monitor reset
// RL3 - self-clock on, irq off: stay in wait, keep PLL and regulator, start check
// RL4 - quality check passes 4096 crystal cycles after failure clears, self-clock ends
// RL5 - after recovery in wait the PLL is off only with pll_off_in_wait
// RL6 - wakeup or external reset after recovery leaves wait on the crystal clock
// RL7 - quality checks repeat without limit while the crystal clock stays absent
// RL8 - leaving wait with a bad clock stays in self-clock mode on vco minimum
// RL9 - all enables set: failure raises the self-clock wakeup and leaves wait
// RL10 - stop gates clocks per pseudo-stop bits, oscillator off unless pseudo-stop
// RL11 - counters and dividers hold their value in stop, never reinitialised
// RL12 - tick and watchdog keep running in pseudo-stop when their bits are set
// RL13 - stop entry asks the regulator and other units for power saving
// RL14 - stop entry: clear PLL select, PLL off, core clock off, system clocks off
// RL15 - pseudo-stop from self-clock keeps checking, PLL and regulator stay on
// RL16 - full stop from self-clock aborts the running quality check
// RL17 - after full stop from self-clock a complete check starts on exit
// RL18 - stop exit leaves PLL select cleared; software sets it again
// RL19 - core holds its wait or stop request until clocks are reported off
`ifndef LPC_PARAMS_SVH
`define LPC_PARAMS_SVH
// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define LPC_A_CTRL 5'h00
`define LPC_A_STATUS 5'h04
`define LPC_A_IRQ_STAT 5'h08
`define LPC_A_IRQ_CLR 5'h0c
`define LPC_A_IRQ_EN 5'h10
`define LPC_CTRL_RST 8'h03
`define LPC_IRQ_EN_RST 3'h0
// ----------------------------------------
// control bit positions
// ----------------------------------------
`define LPC_B_CME 0
`define LPC_B_SELF_CLOCK_MODE_ENABLE 1
`define LPC_B_SELF_CLOCK_IRQ_ENABLE 2
`define LPC_B_PLLOFF 3
`define LPC_B_PSTOP 4
`define LPC_B_TICK 5
`define LPC_B_WDOG 6
`define LPC_B_PLL_CLOCK_SELECT 7
// ----------------------------------------
// interrupt bits and timing
// ----------------------------------------
`define LPC_I_SCM 0
`define LPC_I_GOOD 1
`define LPC_I_CMRST 2
`define LPC_OK_CYCLES 4096
`define LPC_SYNC_RST 3'h4
`endif

// ==== lpc_pkg.sv ====
`default_nettype none
package lpc_pkg;
	typedef enum logic [2:0] {
		LPC_S_RUN, LPC_S_STOP_PLL_CLOCK_SELECT, LPC_S_STOP_PLL, LPC_S_STOP_CORE,
		LPC_S_STOP_SYS, LPC_S_STOP, LPC_S_WAIT
	} lpc_state_t;
	typedef enum logic [1:0] {LPC_SRC_CRYSTAL, LPC_SRC_PLL, LPC_SRC_VCO_MIN} lpc_src_t;
endpackage
`default_nettype wire

// ==== lpc_qc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface lpc_qc_if;
	logic start;
	logic abort;
	logic cm_fail;
	logic osc_lvl;
	logic busy;
	logic good;
	modport ctl(output start, abort, cm_fail, osc_lvl, input busy, good);
	modport chk(input start, abort, cm_fail, osc_lvl, output busy, good);
endinterface // lpc_qc_if
`default_nettype wire

// ==== lpc_qual.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lpc_params.svh"
module lpc_qual #(
	parameter int OK_CYCLES = `LPC_OK_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, low
	lpc_qc_if.chk qc // check control
);
	import lpc_pkg::*;
	localparam int CW = $clog2(OK_CYCLES + 1);
	logic [CW-1:0] cnt_reg;
	logic osc_d_reg;
	logic run_reg;
	logic good_reg;
	logic osc_rise;
	logic last;

	// crystal edge seen on the filtered level
	assign osc_rise = qc.osc_lvl & ~osc_d_reg;
	assign last = run_reg & ~qc.cm_fail & osc_rise & (cnt_reg == CW'(OK_CYCLES - 1));
	assign qc.busy = run_reg;
	assign qc.good = good_reg;

	// edge detector history
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_d_reg <= 1'b0;
		end else begin
			osc_d_reg <= qc.osc_lvl;
		end
	end

	// check runs from start until pass or abort
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_reg <= 1'b0;
		end else if (qc.start) begin
			run_reg <= 1'b1;
		end else if (qc.abort || last) begin
			run_reg <= 1'b0; // RL16
		end
	end

	// crystal cycle counter, restarted while the monitor reports failure
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else if (qc.start) begin
			cnt_reg <= '0; // RL17
		end else if (run_reg && qc.cm_fail) begin
			cnt_reg <= '0; // RL7
		end else if (run_reg && osc_rise) begin
			cnt_reg <= cnt_reg + 1'b1; // RL4
		end
		// an aborted check keeps its count frozen (RL11)
	end

	// one-cycle pass pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			good_reg <= 1'b0;
		end else begin
			good_reg <= last; // RL4
		end
	end

	a_qc_pass_ends: assert property (@(posedge clk) disable iff (!rst_n)
		qc.good |-> !run_reg || $past(qc.start)) else $error("check still busy after pass"); // RL4
endmodule // lpc_qual
`default_nettype wire

// ==== lpc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lpc_params.svh"
module lpc_top #(
	parameter int OK_CYCLES = `LPC_OK_CYCLES
) (
	input wire logic MCLK, // system clock 100 MHz
	input wire logic NRST, // async reset, low
	input wire logic WB_CYC_I, // bus cycle
	input wire logic WB_STB_I, // bus strobe
	input wire logic WB_WE_I, // write enable
	input wire logic [3:0] WB_SEL_I, // byte lanes
	input wire logic [4:0] WB_ADR_I, // byte address
	input wire logic [31:0] WB_DAT_I, // write data
	output logic [31:0] WB_DAT_O, // read data
	output logic WB_ACK_O, // bus ack
	input wire logic WAIT_REQ, // core asks for wait
	input wire logic STOP_REQ, // core asks for stop
	input wire logic WAKE_IRQ, // other wakeup interrupt
	input wire logic CM_FAIL, // clock monitor failure pin
	input wire logic OSC_CLK, // crystal clock sampled
	input wire logic EXT_RST_N, // external reset pin, low
	output logic CLOCKS_OFF, // wait or stop active
	output logic CORE_CLK_EN, // core clock gate
	output logic SYS_CLK_EN, // system clock gate
	output logic PLL_EN, // pll power
	output logic OSC_EN, // oscillator enable
	output logic VOLTAGE_REGULATOR_EN, // regulator full power
	output logic LP_REQ, // power saving request to units
	output logic TICK_EN, // periodic tick clock gate
	output logic WDOG_EN, // watchdog clock gate
	output var lpc_pkg::lpc_src_t SYS_SRC, // system clock source
	output logic CM_RESET, // clock monitor reset pulse
	output logic RESET_SEQ, // start reset sequence pulse
	output logic IRQ // interrupt, high level
);
	import lpc_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	lpc_state_t state_reg, state_next;
	logic [2:0] s1_reg, s2_reg, s3_reg, filt_reg, filt_d_reg;
	logic [7:0] ctrl_reg;
	logic [2:0] irq_stat_reg, irq_en_reg, irq_ev;
	logic scm_reg, scm_next, pend_reg, ack_reg;
	logic wait_rise, stop_rise, wait_d_reg, stop_d_reg;
	logic fail_evt, rst_evt, fail_act, cm_rst_go, scm_go, wake_go;
	logic in_wait, in_stop, pstop, stop_entry, stop_exit;
	logic wb_req, wb_wr;
	logic [31:0] rd_data;
	lpc_qc_if qc();

	// true for stop and wait, the states that report clocks off
	function automatic logic sys_gated(input lpc_state_t s);
		return (s == LPC_S_STOP) || (s == LPC_S_WAIT);
	endfunction

	// true for the stop sequence and stop itself
	function automatic logic stopping(input lpc_state_t s);
		return (s != LPC_S_RUN) && (s != LPC_S_WAIT);
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// three stages, a change counts once stages two and three agree
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			s1_reg <= `LPC_SYNC_RST;
			s2_reg <= `LPC_SYNC_RST;
			s3_reg <= `LPC_SYNC_RST;
			filt_reg <= `LPC_SYNC_RST;
			filt_d_reg <= `LPC_SYNC_RST;
		end else begin
			s1_reg <= {EXT_RST_N, OSC_CLK, CM_FAIL};
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < 3; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					filt_reg[i] <= s3_reg[i];
				end
			end
			filt_d_reg <= filt_reg;
		end
	end

	// core request edges; the core holds a request until clocks are off
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			wait_d_reg <= 1'b0;
			stop_d_reg <= 1'b0;
		end else begin
			wait_d_reg <= WAIT_REQ;
			stop_d_reg <= STOP_REQ;
		end
	end

	// ----------------------------------------
	// event decode
	// ----------------------------------------
	assign wait_rise = WAIT_REQ & ~wait_d_reg; // RL19
	assign stop_rise = STOP_REQ & ~stop_d_reg; // RL19
	assign fail_evt = filt_reg[0] & ~filt_d_reg[0];
	assign rst_evt = ~filt_reg[2] & filt_d_reg[2];
	assign in_wait = state_reg == LPC_S_WAIT;
	assign in_stop = state_reg == LPC_S_STOP;
	assign pstop = ctrl_reg[`LPC_B_PSTOP];
	// the monitor is blind without enable and in full stop
	assign fail_act = fail_evt & ctrl_reg[`LPC_B_CME] & ~(stopping(state_reg) & ~pstop); // RL1
	assign cm_rst_go = fail_act & ~ctrl_reg[`LPC_B_SELF_CLOCK_MODE_ENABLE]; // RL2
	assign scm_go = fail_act & ctrl_reg[`LPC_B_SELF_CLOCK_MODE_ENABLE]; // RL3
	// self-clock event only wakes when its interrupt is enabled
	assign wake_go = (in_wait | in_stop) & (WAKE_IRQ | rst_evt | (scm_go & ctrl_reg[`LPC_B_SELF_CLOCK_IRQ_ENABLE])); // RL6 RL9
	assign stop_entry = (state_next == LPC_S_STOP) & ~in_stop;
	assign stop_exit = in_stop & (state_next == LPC_S_RUN);
	assign scm_next = scm_go | (scm_reg & ~qc.good); // RL4

	// ----------------------------------------
	// mode sequencer
	// ----------------------------------------
	// next state, one step per cycle on stop entry
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			LPC_S_RUN: begin
				if (cm_rst_go) begin
					state_next = LPC_S_RUN;
				end else if (stop_rise) begin
					state_next = LPC_S_STOP_PLL_CLOCK_SELECT; // RL14
				end else if (wait_rise) begin
					state_next = LPC_S_WAIT;
				end
			end
			LPC_S_STOP_PLL_CLOCK_SELECT: state_next = LPC_S_STOP_PLL; // RL14
			LPC_S_STOP_PLL: state_next = LPC_S_STOP_CORE; // RL14
			LPC_S_STOP_CORE: state_next = LPC_S_STOP_SYS; // RL14
			LPC_S_STOP_SYS: state_next = LPC_S_STOP; // RL14
			LPC_S_STOP, LPC_S_WAIT: begin
				if (wake_go || cm_rst_go) begin
					state_next = LPC_S_RUN; // RL6 RL8 RL9
				end
			end
			default: state_next = LPC_S_RUN;
		endcase
	end

	// state register
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= LPC_S_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	// self-clock mode; entry wins over a pass in the same cycle
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			scm_reg <= 1'b0;
		end else begin
			scm_reg <= scm_next; // RL3 RL4 RL8
		end
	end

	// full stop from self-clock owes a complete check on exit
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			pend_reg <= 1'b0;
		end else if (stop_entry && !pstop && scm_reg) begin
			pend_reg <= 1'b1; // RL17
		end else if (stop_exit) begin
			pend_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// quality checker
	// ----------------------------------------
	assign qc.start = scm_go | (stop_exit & pend_reg); // RL3 RL17
	assign qc.abort = stop_entry & ~pstop & scm_reg; // RL16
	assign qc.cm_fail = filt_reg[0]; // RL7
	assign qc.osc_lvl = filt_reg[1];

	lpc_qual #(
		.OK_CYCLES(OK_CYCLES)
	) u_qual (
		.clk(MCLK),
		.rst_n(NRST),
		.qc(qc)
	);

	// ----------------------------------------
	// clock and power outputs
	// ----------------------------------------
	// gates follow the next state so each output is a flop
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			CLOCKS_OFF <= 1'b0;
			CORE_CLK_EN <= 1'b1;
			SYS_CLK_EN <= 1'b1;
		end else begin
			CLOCKS_OFF <= sys_gated(state_next);
			CORE_CLK_EN <= !(sys_gated(state_next) || state_next == LPC_S_STOP_SYS
				|| state_next == LPC_S_STOP_CORE); // RL14
			SYS_CLK_EN <= !(sys_gated(state_next) || state_next == LPC_S_STOP_SYS); // RL14
		end
	end

	// pll and regulator; self-clock keeps them up except in full stop
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			PLL_EN <= 1'b1;
			VOLTAGE_REGULATOR_EN <= 1'b1;
			LP_REQ <= 1'b0;
		end else begin
			if (scm_next && !(stopping(state_next) && !pstop)) begin
				PLL_EN <= 1'b1; // RL3 RL15
			end else if (state_next == LPC_S_WAIT) begin
				PLL_EN <= !ctrl_reg[`LPC_B_PLLOFF]; // RL5
			end else begin
				PLL_EN <= !(stopping(state_next) && state_next != LPC_S_STOP_PLL_CLOCK_SELECT); // RL14
			end
			VOLTAGE_REGULATOR_EN <= !(state_next == LPC_S_STOP && !(scm_next && pstop)); // RL13 RL15
			LP_REQ <= state_next == LPC_S_STOP; // RL13
		end
	end

	// oscillator, tick and watchdog gating in stop
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			OSC_EN <= 1'b1;
			TICK_EN <= 1'b1;
			WDOG_EN <= 1'b1;
		end else begin
			OSC_EN <= !(state_next == LPC_S_STOP && !pstop); // RL10
			TICK_EN <= state_next != LPC_S_STOP || (pstop && ctrl_reg[`LPC_B_TICK]); // RL10 RL12
			WDOG_EN <= state_next != LPC_S_STOP || (pstop && ctrl_reg[`LPC_B_WDOG]); // RL10 RL12
		end
	end

	// system clock source
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			SYS_SRC <= LPC_SRC_CRYSTAL;
		end else if (scm_next) begin
			SYS_SRC <= LPC_SRC_VCO_MIN; // RL8
		end else if (ctrl_reg[`LPC_B_PLL_CLOCK_SELECT] && !stopping(state_next) && state_next != LPC_S_WAIT) begin
			SYS_SRC <= LPC_SRC_PLL;
		end else begin
			SYS_SRC <= LPC_SRC_CRYSTAL; // RL6
		end
	end

	// reset requests, one cycle each
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			CM_RESET <= 1'b0;
			RESET_SEQ <= 1'b0;
		end else begin
			CM_RESET <= cm_rst_go; // RL2
			RESET_SEQ <= cm_rst_go || rst_evt; // RL2 RL6
		end
	end

	// ----------------------------------------
	// registers and interrupt
	// ----------------------------------------
	assign wb_req = WB_CYC_I & WB_STB_I & ~ack_reg;
	assign wb_wr = WB_CYC_I & WB_STB_I & ack_reg & WB_WE_I & WB_SEL_I[0]; // write lands where ack is seen
	assign irq_ev = {cm_rst_go, qc.good, scm_go};

	// control; hardware clears of pll select win over software
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_reg <= `LPC_CTRL_RST;
		end else begin
			if (wb_wr && WB_ADR_I == `LPC_A_CTRL) begin
				ctrl_reg <= WB_DAT_I[7:0];
			end
			if (state_next == LPC_S_STOP_PLL_CLOCK_SELECT || scm_go
				|| (state_next == LPC_S_WAIT && ctrl_reg[`LPC_B_PLLOFF])) begin
				ctrl_reg[`LPC_B_PLL_CLOCK_SELECT] <= 1'b0; // RL14 RL18
			end
		end
	end

	// sticky status, set wins over clear; enable mask
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			irq_stat_reg <= '0;
			irq_en_reg <= `LPC_IRQ_EN_RST;
		end else begin
			if (wb_wr && WB_ADR_I == `LPC_A_IRQ_CLR) begin
				irq_stat_reg <= (irq_stat_reg & ~WB_DAT_I[2:0]) | irq_ev; // RL3 RL9
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_ev; // RL3 RL9
			end
			if (wb_wr && WB_ADR_I == `LPC_A_IRQ_EN) begin
				irq_en_reg <= WB_DAT_I[2:0];
			end
		end
	end

	// read mux, unmapped and write-only read zero
	always_comb begin
		case (WB_ADR_I)
			`LPC_A_CTRL: rd_data = {24'h0, ctrl_reg};
			`LPC_A_STATUS: rd_data = {24'h0, CLOCKS_OFF, OSC_EN, PLL_EN, qc.busy, scm_reg, state_reg};
			`LPC_A_IRQ_STAT: rd_data = {29'h0, irq_stat_reg};
			`LPC_A_IRQ_EN: rd_data = {29'h0, irq_en_reg};
			default: rd_data = 32'h0;
		endcase
	end

	// bus answer one cycle after the request
	always_ff @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			ack_reg <= 1'b0;
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0;
			IRQ <= 1'b0;
		end else begin
			ack_reg <= wb_req;
			WB_ACK_O <= wb_req;
			WB_DAT_O <= wb_req ? rd_data : 32'h0;
			IRQ <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_fail_ignored: assert property (@(posedge MCLK) disable iff (!NRST) // RL1
		(fail_evt && !ctrl_reg[`LPC_B_CME]) |=> !CM_RESET && !$rose(scm_reg)) else $error("unmonitored failure acted on");
	a_cm_reset_now: assert property (@(posedge MCLK) disable iff (!NRST) // RL2
		(in_wait && fail_evt && ctrl_reg[`LPC_B_CME] && !ctrl_reg[`LPC_B_SELF_CLOCK_MODE_ENABLE]) |=> CM_RESET && RESET_SEQ)
		else $error("no clock monitor reset");
	a_scm_stays_wait: assert property (@(posedge MCLK) disable iff (!NRST) // RL3
		(in_wait && scm_go && !ctrl_reg[`LPC_B_SELF_CLOCK_IRQ_ENABLE] && !WAKE_IRQ && !rst_evt)
		|=> in_wait && scm_reg && PLL_EN && VOLTAGE_REGULATOR_EN && irq_stat_reg[`LPC_I_SCM]) else $error("self-clock wait wrong");
	a_scm_ends_good: assert property (@(posedge MCLK) disable iff (!NRST) // RL4
		(qc.good && !scm_go) |=> !scm_reg) else $error("self-clock kept after pass");
	a_pll_wait_off: assert property (@(posedge MCLK) disable iff (!NRST) // RL5
		(in_wait && !scm_reg && $past(in_wait && !scm_reg && ctrl_reg[`LPC_B_PLLOFF])) |-> !PLL_EN && VOLTAGE_REGULATOR_EN)
		else $error("pll not off in wait");
	a_wake_exit: assert property (@(posedge MCLK) disable iff (!NRST) // RL6
		(in_wait && WAKE_IRQ) |=> state_reg == LPC_S_RUN ##1 !CLOCKS_OFF) else $error("wait not left");
	a_scm_source: assert property (@(posedge MCLK) disable iff (!NRST) // RL8
		scm_reg |-> SYS_SRC == LPC_SRC_VCO_MIN) else $error("self-clock source wrong");
	a_stop_order: assert property (@(posedge MCLK) disable iff (!NRST) // RL14
		(state_reg == LPC_S_STOP_PLL_CLOCK_SELECT && !pstop) |-> !ctrl_reg[`LPC_B_PLL_CLOCK_SELECT] ##1 !PLL_EN && CORE_CLK_EN
		##1 !CORE_CLK_EN && SYS_CLK_EN ##1 !SYS_CLK_EN ##1 CLOCKS_OFF) else $error("stop order broken");
	a_full_stop_osc: assert property (@(posedge MCLK) disable iff (!NRST) // RL10
		(in_stop && $past(in_stop && !pstop)) |-> !OSC_EN && LP_REQ && !TICK_EN) else $error("full stop gating");
	a_check_abort: assert property (@(posedge MCLK) disable iff (!NRST) // RL16
		qc.abort |=> !qc.busy) else $error("check not aborted");
	c_scm_in_wait: cover property (@(posedge MCLK) disable iff (!NRST) in_wait && scm_go);
	c_full_stop: cover property (@(posedge MCLK) disable iff (!NRST) in_stop && !pstop);
	c_wake_scm: cover property (@(posedge MCLK) disable iff (!NRST) wake_go && scm_next);
endmodule // lpc_top
`default_nettype wire

// ==== lpc_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// core stand-in: asks for wait or stop
// ----------------------------------------
module lpc_core_model (
	input wire logic clk, // system clock
	input wire logic rst_n, // async reset, low
	input wire logic go, // one-cycle start pulse
	input wire logic kind_wait, // 1 wait, 0 stop
	input wire logic [3:0] dly, // cycles before asking
	input wire logic clocks_off, // block reports clocks off
	output logic wait_req, // wait request
	output logic stop_req // stop request
);
	logic [4:0] cnt_reg;
	logic kind_reg;
	// ask after a delay, hold until clocks are off, then let go
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 5'h0;
			kind_reg <= 1'b0;
			wait_req <= 1'b0;
			stop_req <= 1'b0;
		end else if (wait_req || stop_req) begin
			if (clocks_off) begin
				wait_req <= 1'b0;
				stop_req <= 1'b0;
			end
		end else if (cnt_reg != 5'h0) begin
			cnt_reg <= cnt_reg - 5'h1;
			if (cnt_reg == 5'h1) begin
				wait_req <= kind_reg;
				stop_req <= !kind_reg;
			end
		end else if (go) begin
			cnt_reg <= {1'b0, dly} + 5'h1;
			kind_reg <= kind_wait;
		end
	end
endmodule // lpc_core_model
`default_nettype wire

// ==== lpc_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lpc_params.svh"
module lpc_top_tb_top;
	import lpc_pkg::*;
	localparam int OKC = 8;
	logic mclk, nrst, cyc, stb, we, wake, cmf, osc, ext_n, go, kw, osc_on;
	logic ack, wreq, sreq, coff, core_en, sys_en, pll_en, osc_en, voltage_regulator_en, lp, tick_en, wdog_en, cmr, rseq, irq;
	logic [1:0] ocnt;
	logic [3:0] dly;
	logic [4:0] adr;
	logic [31:0] dat, dato, q;
	lpc_src_t src;
	int err_total, n_compared, seed;
	logic [7:0] regs_m[int];
	lpc_top #(.OK_CYCLES(OKC)) lpc_top_i (.MCLK(mclk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_SEL_I(4'hf), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack),
		.WAIT_REQ(wreq), .STOP_REQ(sreq), .WAKE_IRQ(wake), .CM_FAIL(cmf), .OSC_CLK(osc), .EXT_RST_N(ext_n),
		.CLOCKS_OFF(coff), .CORE_CLK_EN(core_en), .SYS_CLK_EN(sys_en), .PLL_EN(pll_en), .OSC_EN(osc_en),
		.VOLTAGE_REGULATOR_EN(voltage_regulator_en), .LP_REQ(lp), .TICK_EN(tick_en), .WDOG_EN(wdog_en), .SYS_SRC(src),
		.CM_RESET(cmr), .RESET_SEQ(rseq), .IRQ(irq));
	lpc_core_model lpc_core_model_i (.clk(mclk), .rst_n(nrst), .go(go), .kind_wait(kw), .dly(dly),
		.clocks_off(coff), .wait_req(wreq), .stop_req(sreq));
	// ----------------------------------------
	// clocks and helpers
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// crystal stand-in: toggles every 4 cycles, freezes while absent
	always @(posedge mclk) begin
		ocnt <= ocnt + 2'h1;
		if (osc_on && ocnt == 2'h3) osc <= ~osc;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] e, input string m);
		n_compared++;
		if (got !== e) begin
			err_total++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, e);
		end
	endtask
	task automatic settle();
		@(posedge mclk);
		#1;
	endtask
	// one classic bus cycle, released after ack is sampled or after 20 cycles without ack
	task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) chk(32'h0, 32'h1, "no ack");
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		wb(1'b1, a, {24'h0, d});
		if (a == `LPC_A_CTRL) regs_m[a] = d;
		if (a == `LPC_A_IRQ_EN) regs_m[a] = d & 8'h07;
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(q, e, "read");
	endtask
	function automatic logic [31:0] mv(input logic [4:0] a);
		return regs_m.exists(a) ? {24'h0, regs_m[a]} : 32'h0;
	endfunction
	// core asks; returns at the edge where the request is taken
	task automatic enter(input logic w);
		int k;
		@(posedge mclk);
		go <= 1'b1;
		kw <= w;
		dly <= 4'($random(seed));
		@(posedge mclk);
		go <= 1'b0;
		k = 0;
		while ((w ? wreq : sreq) !== 1'b1 && k < 40) begin
			@(posedge mclk);
			k++;
		end
	endtask
	task automatic wake_up();
		@(posedge mclk);
		wake <= 1'b1;
		@(posedge mclk);
		wake <= 1'b0;
		settle();
	endtask
	task automatic chk_irq(input logic e);
		settle();
		chk(irq, e, "irq level");
	endtask
	task automatic stop_walk(input logic [2:0] b);
		wr(`LPC_A_CTRL, {1'b1, b, 4'h1});
		enter(1'b0);
		for (int k = 1; k <= 5; k++) begin
			settle();
			chk({pll_en, core_en, sys_en, coff}, {k < 1, k < 2, k < 3, k > 3}, "stop step");
		end
		chk({osc_en, tick_en, wdog_en, voltage_regulator_en, lp}, {b[0], b[0] & b[1], b[0] & b[2], 2'b01}, "gates");
		wake_up();
		chk({core_en, sys_en, pll_en, coff, src}, {4'he, LPC_SRC_CRYSTAL}, "stop exit");
		regs_m[0] = regs_m[0] & 8'h7f;
		rd(`LPC_A_CTRL, mv(`LPC_A_CTRL));
	endtask
	// crystal loss during wait for one enable setting
	task automatic fail_case(input logic [2:0] c);
		logic po;
		logic [1:0] seen;
		int k;
		po = 1'($random(seed));
		seen = 2'b00;
		k = 0;
		wr(`LPC_A_CTRL, {4'h0, po, c});
		enter(1'b1);
		settle();
		chk({coff, core_en, sys_en, pll_en}, {3'b100, !po}, "wait entry");
		@(posedge mclk);
		cmf <= 1'b1;
		osc_on <= 1'b0;
		repeat (12) begin
			@(posedge mclk);
			seen = seen | {cmr, rseq};
		end
		#1;
		chk(seen, {2{c == 3'h1}}, "monitor reset");
		chk({coff, src}, {c == 3'h2 || c == 3'h3, (c == 3'h3 || c == 3'h7) ? LPC_SRC_VCO_MIN : LPC_SRC_CRYSTAL}, "fail");
		if (c == 3'h3) begin
			chk(pll_en, 1'b1, "pll kept");
			repeat (OKC * 24) @(posedge mclk);
			chk({coff, src}, {1'b1, LPC_SRC_VCO_MIN}, "still bad");
		end
		if (c == 3'h7) begin
			wr(`LPC_A_IRQ_EN, 8'h01);
			chk_irq(1'b1);
			wr(`LPC_A_IRQ_EN, 8'h00);
			chk_irq(1'b0);
			wr(`LPC_A_IRQ_CLR, 8'h01);
			wr(`LPC_A_IRQ_EN, 8'h01);
			chk_irq(1'b0);
			wr(`LPC_A_CTRL, 8'h17);
			enter(1'b0);
			repeat (8) @(posedge mclk);
			#1;
			chk({pll_en, voltage_regulator_en, coff}, 3'h7, "pseudo stop");
			wake_up();
			chk(src, LPC_SRC_VCO_MIN, "exit bad clock");
			wr(`LPC_A_CTRL, 8'h07);
			enter(1'b0);
			repeat (6) @(posedge mclk);
			#1;
			chk({pll_en, voltage_regulator_en, coff, osc_en}, 4'h2, "full stop");
			rd(`LPC_A_STATUS, 32'h8d);
			wake_up();
			rd(`LPC_A_STATUS, 32'h78);
		end
		@(posedge mclk);
		cmf <= 1'b0;
		osc_on <= 1'b1;
		if (c == 3'h3 || c == 3'h7) begin
			while (src !== LPC_SRC_CRYSTAL && k < 400) begin
				@(posedge mclk);
				k++;
			end
			chk(k >= OKC * 8 - 8 && k < 400, 1'b1, "check length");
		end
		repeat (2) @(posedge mclk);
		#1;
		if (c == 3'h3) chk({coff, pll_en, voltage_regulator_en}, {1'b1, !po, 1'b1}, "recovered");
		if (c == 3'h2 || c == 3'h3) begin
			wake_up();
			chk({coff, src}, {1'b0, LPC_SRC_CRYSTAL}, "wake exit");
		end
		rd(`LPC_A_IRQ_STAT, (c == 3'h1) ? 32'h4 : (c == 3'h2) ? 32'h0 : (c == 3'h3) ? 32'h3 : 32'h2);
		wr(`LPC_A_IRQ_CLR, 8'h07);
		wr(`LPC_A_IRQ_EN, 8'h00);
		$display("test clock loss %0d done", c);
	endtask
	task automatic ext_reset();
		logic s;
		s = 1'b0;
		enter(1'b1);
		@(posedge mclk);
		ext_n <= 1'b0;
		repeat (12) begin
			@(posedge mclk);
			s = s | rseq;
		end
		ext_n <= 1'b1;
		#1;
		chk({s, coff, src}, {2'b10, LPC_SRC_CRYSTAL}, "external reset");
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		#200000;
		err_total++;
		stop_test();
	end
	initial begin
		seed = 32'h87b3;
		{cyc, stb, we, wake, cmf, osc, go, kw, nrst} = '0;
		ext_n = 1'b1;
		osc_on = 1'b1;
		ocnt = 2'h0;
		dly = 4'h0;
		adr = 5'h0;
		dat = 32'h0;
		err_total = 0;
		n_compared = 0;
		regs_m[`LPC_A_CTRL] = `LPC_CTRL_RST;
		regs_m[`LPC_A_IRQ_EN] = 8'h00;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		#1;
		chk({core_en, sys_en, pll_en, osc_en, voltage_regulator_en, tick_en, wdog_en, coff, lp, irq, src}, 12'hfe0, "reset");
		rd(`LPC_A_CTRL, mv(`LPC_A_CTRL));
		rd(`LPC_A_IRQ_EN, mv(`LPC_A_IRQ_EN));
		wr(5'h14, 8'hff);
		rd(5'h14, mv(5'h14));
		rd(`LPC_A_IRQ_STAT, 32'h0);
		$display("test registers done");
		repeat (4) stop_walk(3'($random(seed)));
		$display("test stop entry done");
		fail_case(3'h2);
		fail_case(3'h1);
		fail_case(3'h3);
		fail_case(3'h7);
		ext_reset();
		$display("test external reset done");
		stop_test();
	end
endmodule // lpc_top_tb_top
`default_nettype wire
